// ===== bmu_pkg.sv
// bit manipulation unit: shared types, op codes, state layout and reset values
// assumes one clock and a decoder that hands over one decoded bit instruction at a time
package bmu_pkg;

    // ****************************************************************
    // widths and field positions
    // ****************************************************************
    localparam int unsigned BMU_DATA_W = 8;
    localparam int unsigned BMU_BITNO_W = 3;
    localparam int unsigned BMU_ADDR_W = 16;
    localparam int unsigned BMU_BITNO_LSB = 0;

    // ****************************************************************
    // decoded bit instructions and sequencer states
    // ****************************************************************
    typedef enum logic [3:0] {
        BMU_SET_ONE_BIT = 4'h0,
        BMU_CLEAR_ONE_BIT = 4'h1,
        BMU_INVERT_ONE_BIT = 4'h2,
        BMU_TEST_ONE_BIT = 4'h3,
        BMU_CARRY_AND_BIT = 4'h4,
        BMU_CARRY_AND_INVERTED_BIT = 4'h5,
        BMU_CARRY_OR_BIT = 4'h6,
        BMU_CARRY_OR_INVERTED_BIT = 4'h7,
        BMU_CARRY_XOR_BIT = 4'h8,
        BMU_CARRY_XOR_INVERTED_BIT = 4'h9,
        BMU_LOAD_BIT_TO_CARRY = 4'hA,
        BMU_LOAD_INVERTED_BIT_TO_CARRY = 4'hB,
        BMU_STORE_CARRY_TO_BIT = 4'hC,
        BMU_STORE_INVERTED_CARRY_TO_BIT = 4'hD
    } bmu_op_t;

    typedef enum logic [1:0] {
        BMU_ST_IDLE = 2'b00,
        BMU_ST_READ = 2'b01,
        BMU_ST_EXEC = 2'b10,
        BMU_ST_WRITE = 2'b11
    } bmu_fsm_t;

    // ****************************************************************
    // request, response and state carriers
    // ****************************************************************
    typedef struct packed {
        bmu_op_t op;
        logic bitno_from_reg;
        logic [BMU_BITNO_W-1:0] imm_bitno;
        logic [BMU_DATA_W-1:0] reg_bitno;
        logic operand_in_mem;
        logic [BMU_DATA_W-1:0] reg_operand;
        logic [BMU_ADDR_W-1:0] mem_addr;
        logic carry;
        logic zero;
    } bmu_req_t;

    typedef struct packed {
        logic [BMU_DATA_W-1:0] data;
        logic data_we;
        logic carry;
        logic carry_we;
        logic zero;
        logic zero_we;
        logic refused;
    } bmu_rsp_t;

    typedef struct packed {
        bmu_fsm_t state;
        bmu_req_t req;
        logic [BMU_BITNO_W-1:0] bitno;
        logic [BMU_DATA_W-1:0] operand;
        logic ready;
        logic done;
        logic mem_rd;
        logic mem_wr;
        logic [BMU_ADDR_W-1:0] mem_addr;
        logic [BMU_DATA_W-1:0] mem_wdata;
        bmu_rsp_t rsp;
    } bmu_st_t;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam bmu_rsp_t BMU_RSP_RST = '0;
    localparam bmu_st_t BMU_ST_RST = '{state: BMU_ST_IDLE, req: '0, bitno: '0, operand: '0,
        ready: 1'b1, done: 1'b0, mem_rd: 1'b0, mem_wr: 1'b0, mem_addr: '0, mem_wdata: '0,
        rsp: BMU_RSP_RST};

    // ****************************************************************
    // op classes
    // ****************************************************************
    function automatic logic bmu_is_inverted(input bmu_op_t op);
        return op inside {BMU_CARRY_AND_INVERTED_BIT, BMU_CARRY_OR_INVERTED_BIT,
            BMU_CARRY_XOR_INVERTED_BIT, BMU_LOAD_INVERTED_BIT_TO_CARRY,
            BMU_STORE_INVERTED_CARRY_TO_BIT};
    endfunction

    function automatic logic bmu_modifies(input bmu_op_t op);
        return op inside {BMU_SET_ONE_BIT, BMU_CLEAR_ONE_BIT, BMU_INVERT_ONE_BIT,
            BMU_STORE_CARRY_TO_BIT, BMU_STORE_INVERTED_CARRY_TO_BIT};
    endfunction

    function automatic logic bmu_writes_carry(input bmu_op_t op);
        return op inside {[BMU_CARRY_AND_BIT:BMU_LOAD_INVERTED_BIT_TO_CARRY]};
    endfunction

endpackage

// ===== bmu_bit_alu.sv
// bit manipulation unit: combinational bit operator on one byte operand
// assumes the caller registers every result and supplies a valid op
`timescale 1ns/10ps
module bmu_bit_alu (
    input bmu_pkg::bmu_op_t op_i,
    input logic [bmu_pkg::BMU_DATA_W-1:0] operand_i,
    input logic [bmu_pkg::BMU_BITNO_W-1:0] bitno_i,
    input logic carry_i,
    input logic zero_i,
    output logic [bmu_pkg::BMU_DATA_W-1:0] data_o,
    output logic carry_o,
    output logic zero_o
);
    import bmu_pkg::*;

    logic sel_bit;
    logic mod_bit;

    // the addressed operand bit
    assign sel_bit = operand_i[bitno_i];

    // value that replaces the addressed bit; other ops keep it
    always_comb begin
        case (op_i)
            BMU_SET_ONE_BIT: mod_bit = 1'b1; // RQ1
            BMU_CLEAR_ONE_BIT: mod_bit = 1'b0; // RQ2
            BMU_INVERT_ONE_BIT: mod_bit = ~sel_bit; // RQ3
            BMU_STORE_CARRY_TO_BIT: mod_bit = carry_i; // RQ14
            BMU_STORE_INVERTED_CARRY_TO_BIT: mod_bit = ~carry_i; // RQ15
            default: mod_bit = sel_bit;
        endcase
    end

    // only the addressed bit may change, all seven others pass through
    for (genvar i = 0; i < BMU_DATA_W; i++) begin : g_bit
        assign data_o[i] = (bitno_i == BMU_BITNO_W'(i)) ? mod_bit : operand_i[i]; // RQ1
    end

    // carry combines with the addressed bit; non-carry ops return carry untouched
    always_comb begin
        case (op_i)
            BMU_CARRY_AND_BIT: carry_o = carry_i & sel_bit; // RQ6
            BMU_CARRY_AND_INVERTED_BIT: carry_o = carry_i & ~sel_bit; // RQ7
            BMU_CARRY_OR_BIT: carry_o = carry_i | sel_bit; // RQ8
            BMU_CARRY_OR_INVERTED_BIT: carry_o = carry_i | ~sel_bit; // RQ9
            BMU_CARRY_XOR_BIT: carry_o = carry_i ^ sel_bit; // RQ10
            BMU_CARRY_XOR_INVERTED_BIT: carry_o = carry_i ^ ~sel_bit; // RQ11
            BMU_LOAD_BIT_TO_CARRY: carry_o = sel_bit; // RQ12
            BMU_LOAD_INVERTED_BIT_TO_CARRY: carry_o = ~sel_bit; // RQ13
            default: carry_o = carry_i; // RQ18
        endcase
    end

    // zero reflects the inverse of the tested bit
    assign zero_o = (op_i == BMU_TEST_ONE_BIT) ? ~sel_bit : zero_i; // RQ4
endmodule

// ===== bmu_bit_manip.sv
// bit manipulation unit: sequencer for the fourteen single-bit instructions
// assumes a decoder that presents one request at a time and a byte memory port
// that answers each read or write strobe with a one-cycle acknowledge
//
// Overview of operation
// RQ1: set-bit forces the selected bit to one, others unchanged.
// RQ2: clear-bit forces the selected bit to zero, others unchanged.
// RQ3: invert-bit complements the selected bit, others unchanged.
// RQ4: test-bit loads zero flag with the inverse of the selected bit.
// RQ5: basic ops take bit number from immediate or register low three bits.
// RQ6: bit-and makes carry the AND of carry and selected bit.
// RQ7: inverted bit-and ANDs carry with the inverted selected bit.
// RQ8: bit-or makes carry the OR of carry and selected bit.
// RQ9: inverted bit-or ORs carry with the inverted selected bit.
// RQ10: bit-xor makes carry the XOR of carry and selected bit.
// RQ11: inverted bit-xor XORs carry with the inverted selected bit.
// RQ12: bit-load copies the selected bit into carry.
// RQ13: inverted bit-load copies the inverted selected bit into carry.
// RQ14: bit-store writes carry into the selected bit, others unchanged.
// RQ15: inverted bit-store writes inverted carry into the selected bit.
// RQ16: inverted carry ops accept only an immediate bit number.
// RQ17: modified memory bytes are read whole, changed, written back whole.
// RQ18: test and carry-only ops leave operand and other flags untouched.
`timescale 1ns/10ps
module bmu_bit_manip #(
    parameter int unsigned MEM_ADDR_W = bmu_pkg::BMU_ADDR_W
) (
    input logic sys_clk_i,
    input logic rst_n_i,
    input logic req_valid_i,
    input bmu_pkg::bmu_req_t req_i,
    output logic req_ready_o,
    output logic done_o,
    output bmu_pkg::bmu_rsp_t rsp_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [MEM_ADDR_W-1:0] mem_addr_o,
    output logic [bmu_pkg::BMU_DATA_W-1:0] mem_wdata_o,
    input logic [bmu_pkg::BMU_DATA_W-1:0] mem_rdata_i,
    input logic mem_ack_i
);
    import bmu_pkg::*;

    // ****************************************************************
    // elaboration check
    // ****************************************************************
    // the request carrier fixes the address width, so nothing else is served
    if (MEM_ADDR_W != BMU_ADDR_W) begin : g_bad_addr_w
        $error("MEM_ADDR_W must match the request address width");
    end

    // ****************************************************************
    // state and bit operator
    // ****************************************************************
    bmu_st_t st_ff;
    bmu_st_t nxt_st;
    logic [BMU_DATA_W-1:0] alu_data;
    logic alu_carry;
    logic alu_zero;
    logic sel_bit;
    logic exec_now;
    logic accept_now;

    bmu_bit_alu u_alu (
        .op_i(st_ff.req.op),
        .operand_i(st_ff.operand),
        .bitno_i(st_ff.bitno),
        .carry_i(st_ff.req.carry),
        .zero_i(st_ff.req.zero),
        .data_o(alu_data),
        .carry_o(alu_carry),
        .zero_o(alu_zero)
    );

    // helpers used only by the checks below; the sequencer decodes st_ff and req_valid_i directly
    assign sel_bit = st_ff.operand[st_ff.bitno];
    assign exec_now = (st_ff.state == BMU_ST_EXEC);
    assign accept_now = req_valid_i && st_ff.ready;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // idle -> (read) -> exec -> (write) -> idle; the response stands until the next accept
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        case (st_ff.state)
            BMU_ST_IDLE: begin
                if (req_valid_i) begin
                    nxt_st.req = req_i;
                    nxt_st.rsp = BMU_RSP_RST;
                    nxt_st.operand = req_i.reg_operand;
                    // register source uses only its low three bits
                    if (req_i.bitno_from_reg) begin
                        nxt_st.bitno = req_i.reg_bitno[BMU_BITNO_LSB +: BMU_BITNO_W]; // RQ5
                    end else begin
                        nxt_st.bitno = req_i.imm_bitno; // RQ5
                    end
                    if (bmu_is_inverted(req_i.op) && req_i.bitno_from_reg) begin
                        // inverted forms have no register bit number: refuse, touch nothing
                        nxt_st.rsp.refused = 1'b1; // RQ16
                        nxt_st.rsp.carry = req_i.carry;
                        nxt_st.rsp.zero = req_i.zero;
                        nxt_st.rsp.data = req_i.reg_operand;
                        nxt_st.done = 1'b1;
                    end else if (req_i.operand_in_mem) begin
                        // whole byte is fetched even when only one bit matters
                        nxt_st.mem_rd = 1'b1; // RQ17
                        nxt_st.mem_addr = req_i.mem_addr;
                        nxt_st.state = BMU_ST_READ;
                    end else begin
                        nxt_st.state = BMU_ST_EXEC;
                    end
                end
            end
            BMU_ST_READ: begin
                if (mem_ack_i) begin
                    nxt_st.mem_rd = 1'b0;
                    nxt_st.operand = mem_rdata_i; // RQ17
                    nxt_st.state = BMU_ST_EXEC;
                end
            end
            BMU_ST_EXEC: begin
                nxt_st.rsp.data = alu_data;
                nxt_st.rsp.carry = alu_carry;
                nxt_st.rsp.zero = alu_zero;
                nxt_st.rsp.carry_we = bmu_writes_carry(st_ff.req.op); // RQ18
                nxt_st.rsp.zero_we = (st_ff.req.op == BMU_TEST_ONE_BIT); // RQ4
                if (bmu_modifies(st_ff.req.op) && st_ff.req.operand_in_mem) begin
                    // write back the full byte to the same address
                    nxt_st.mem_wr = 1'b1; // RQ17
                    nxt_st.mem_wdata = alu_data;
                    nxt_st.state = BMU_ST_WRITE;
                end else begin
                    // register operand is written only by modifying ops
                    nxt_st.rsp.data_we = bmu_modifies(st_ff.req.op); // RQ18
                    nxt_st.done = 1'b1;
                    nxt_st.state = BMU_ST_IDLE;
                end
            end
            BMU_ST_WRITE: begin
                if (mem_ack_i) begin
                    nxt_st.mem_wr = 1'b0;
                    nxt_st.done = 1'b1;
                    nxt_st.state = BMU_ST_IDLE;
                end
            end
            default: begin
                nxt_st = BMU_ST_RST;
            end
        endcase
        nxt_st.ready = (nxt_st.state == BMU_ST_IDLE);
    end

    // single state register; reset loads constants only
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= BMU_ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // every output is a field of the state register
    assign req_ready_o = st_ff.ready;
    assign done_o = st_ff.done;
    assign rsp_o = st_ff.rsp;
    assign mem_rd_o = st_ff.mem_rd;
    assign mem_wr_o = st_ff.mem_wr;
    assign mem_addr_o = st_ff.mem_addr;
    assign mem_wdata_o = st_ff.mem_wdata;

    // ****************************************************************
    // checks
    // ****************************************************************
    a_set_bit_one: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ1
        exec_now && st_ff.req.op == BMU_SET_ONE_BIT
        |=> rsp_o.data == ($past(st_ff.operand) | (8'h01 << $past(st_ff.bitno))))
        else $error("set-bit result wrong");

    a_clear_bit_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ2
        exec_now && st_ff.req.op == BMU_CLEAR_ONE_BIT
        |=> rsp_o.data == ($past(st_ff.operand) & ~(8'h01 << $past(st_ff.bitno))))
        else $error("clear-bit result wrong");

    a_invert_bit_flip: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ3
        exec_now && st_ff.req.op == BMU_INVERT_ONE_BIT
        |=> rsp_o.data == ($past(st_ff.operand) ^ (8'h01 << $past(st_ff.bitno))))
        else $error("invert-bit result wrong");

    a_test_bit_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ4
        exec_now && st_ff.req.op == BMU_TEST_ONE_BIT
        |=> rsp_o.zero_we && rsp_o.zero == !$past(sel_bit) && !rsp_o.carry_we)
        else $error("test-bit zero flag wrong");

    a_reg_bitno_low: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ5
        accept_now && req_i.bitno_from_reg && !bmu_is_inverted(req_i.op)
        |=> st_ff.bitno == BMU_BITNO_W'($past(req_i.reg_bitno)))
        else $error("register bit number not taken from low bits");

    a_carry_and_ops: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ6
        exec_now && st_ff.req.op == BMU_CARRY_AND_BIT
        |=> rsp_o.carry_we && rsp_o.carry == ($past(st_ff.req.carry) & $past(sel_bit)))
        else $error("bit-and carry wrong");

    a_carry_iand_ops: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ7
        exec_now && st_ff.req.op == BMU_CARRY_AND_INVERTED_BIT
        |=> rsp_o.carry == ($past(st_ff.req.carry) & !$past(sel_bit)))
        else $error("inverted bit-and carry wrong");

    a_carry_or_ops: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ8
        exec_now && st_ff.req.op == BMU_CARRY_OR_BIT
        |=> rsp_o.carry == ($past(st_ff.req.carry) | $past(sel_bit)))
        else $error("bit-or carry wrong");

    a_carry_ior_ops: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ9
        exec_now && st_ff.req.op == BMU_CARRY_OR_INVERTED_BIT
        |=> rsp_o.carry == ($past(st_ff.req.carry) | !$past(sel_bit)))
        else $error("inverted bit-or carry wrong");

    a_carry_xor_ops: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ10
        exec_now && st_ff.req.op == BMU_CARRY_XOR_BIT
        |=> rsp_o.carry == ($past(st_ff.req.carry) ^ $past(sel_bit)))
        else $error("bit-xor carry wrong");

    a_carry_ixor_ops: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ11
        exec_now && st_ff.req.op == BMU_CARRY_XOR_INVERTED_BIT
        |=> rsp_o.carry == ($past(st_ff.req.carry) ^ !$past(sel_bit)))
        else $error("inverted bit-xor carry wrong");

    a_load_bit_carry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ12
        exec_now && st_ff.req.op == BMU_LOAD_BIT_TO_CARRY
        |=> rsp_o.carry == $past(sel_bit) && !rsp_o.data_we)
        else $error("bit-load carry wrong");

    a_iload_bit_carry: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ13
        exec_now && st_ff.req.op == BMU_LOAD_INVERTED_BIT_TO_CARRY
        |=> rsp_o.carry == !$past(sel_bit))
        else $error("inverted bit-load carry wrong");

    a_store_carry_bit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ14
        exec_now && st_ff.req.op == BMU_STORE_CARRY_TO_BIT
        |=> rsp_o.data[$past(st_ff.bitno)] == $past(st_ff.req.carry) && !rsp_o.carry_we)
        else $error("bit-store result wrong");

    a_istore_carry_bit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ15
        exec_now && st_ff.req.op == BMU_STORE_INVERTED_CARRY_TO_BIT
        |=> rsp_o.data[$past(st_ff.bitno)] == !$past(st_ff.req.carry))
        else $error("inverted bit-store result wrong");

    a_inverted_reg_refused: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ16
        accept_now && bmu_is_inverted(req_i.op) && req_i.bitno_from_reg
        |=> done_o && rsp_o.refused && !rsp_o.data_we && !rsp_o.carry_we && !mem_rd_o)
        else $error("inverted op with register bit number not refused");

    a_mem_write_back: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ17
        $rose(mem_wr_o)
        |-> $past(st_ff.state) == BMU_ST_EXEC && mem_addr_o == $past(mem_addr_o)
            && mem_wdata_o == $past(alu_data))
        else $error("memory write not a read-modify-write of the same byte");

    a_no_stray_write: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // RQ18
        (mem_wr_o || (done_o && rsp_o.data_we)) |-> bmu_modifies(st_ff.req.op))
        else $error("operand byte written by a non-modifying op");
endmodule

// ===== bmu_mem_model.sv
// memory port partner: small byte store that acknowledges each strobe
// assumes level strobes held until the one-cycle acknowledge, one clock domain
`timescale 1ns/10ps
module bmu_mem_model (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o,
    output logic mem_ack_o,
    output logic [7:0] wr_count_o,
    output logic order_err_o
);
    logic [7:0] mem [16];
    logic [2:0] wait_ff;
    logic rd_seen_ff;
    // ack after no wait or three wait cycles; read data off the ack cycle toggles so it is never trusted
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 16; i++) begin
                mem[i] <= 8'hA5 ^ 8'(i * 17);
            end
            mem_rdata_o <= 8'h00;
            mem_ack_o <= 1'b0;
            wait_ff <= 3'h0;
            rd_seen_ff <= 1'b0;
            wr_count_o <= 8'h00;
            order_err_o <= 1'b0;
        end else begin
            mem_rdata_o <= ~mem_rdata_o;
            mem_ack_o <= 1'b0;
            if (!mem_ack_o && (mem_rd_i || mem_wr_i)) begin
                if (wait_ff < (slow_i ? 3'h3 : 3'h0)) begin
                    wait_ff <= wait_ff + 3'h1;
                end else begin
                    wait_ff <= 3'h0;
                    mem_ack_o <= 1'b1;
                    if (mem_rd_i) begin
                        mem_rdata_o <= mem[mem_addr_i[3:0]];
                        rd_seen_ff <= 1'b1;
                    end else begin
                        mem[mem_addr_i[3:0]] <= mem_wdata_i;
                        wr_count_o <= wr_count_o + 8'h01;
                        order_err_o <= order_err_o | !rd_seen_ff;
                        rd_seen_ff <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

// ===== bmu_bit_manip_test.sv
// bit manipulation unit testbench: drives decoded requests, judges responses and memory traffic
// assumes the memory partner model; inputs change on the falling edge
`timescale 1ns/10ps
module bmu_bit_manip_test;
    import bmu_pkg::*;
    logic sys_clk, rst_n, req_valid, ready, done, mem_rd, mem_wr, mem_ack, slow, order_err;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, mem_rdata, wr_count;
    bmu_req_t req;
    bmu_rsp_t rsp;
    int failures = 0;
    int compares = 0;

    // ****************************************************************
    // clock, design and partner
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    bmu_bit_manip #(.MEM_ADDR_W(16)) dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .req_valid_i(req_valid),
        .req_i(req), .req_ready_o(ready), .done_o(done), .rsp_o(rsp), .mem_rd_o(mem_rd), .mem_wr_o(mem_wr),
        .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack));
    bmu_mem_model peer (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .slow_i(slow), .mem_rd_i(mem_rd),
        .mem_wr_i(mem_wr), .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata),
        .mem_ack_o(mem_ack), .wr_count_o(wr_count), .order_err_o(order_err));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic wrap_up();
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            failures++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    function automatic logic is_inv(input bmu_op_t op);
        return op inside {BMU_CARRY_AND_INVERTED_BIT, BMU_CARRY_OR_INVERTED_BIT, BMU_CARRY_XOR_INVERTED_BIT,
            BMU_LOAD_INVERTED_BIT_TO_CARRY, BMU_STORE_INVERTED_CARRY_TO_BIT};
    endfunction
    // the unused bit-number source carries a wrong value so a mixed-up source shows
    function automatic bmu_req_t mk(bmu_op_t op, logic fr, logic [2:0] b, logic m, logic [7:0] d, logic c, logic z);
        bmu_req_t r;
        r = '0;
        r.op = op;
        r.bitno_from_reg = fr;
        r.imm_bitno = fr ? ~b : b;
        r.reg_bitno = fr ? {5'b1_0101, b} : {5'b1_1111, ~b};
        r.operand_in_mem = m;
        r.reg_operand = d;
        r.mem_addr = 16'h0003;
        r.carry = c;
        r.zero = z;
        return r;
    endfunction
    // expected answer worked out bit by bit; unchanged flags echo their inputs
    function automatic bmu_rsp_t expect_rsp(bmu_op_t op, logic [7:0] d, logic [2:0] b, logic c, logic z, logic m);
        bmu_rsp_t e;
        logic s;
        s = d[b];
        e = '0;
        e.data = d;
        e.carry = c;
        e.zero = z;
        case (op)
            BMU_SET_ONE_BIT: e.data[b] = 1'b1;
            BMU_CLEAR_ONE_BIT: e.data[b] = 1'b0;
            BMU_INVERT_ONE_BIT: e.data[b] = ~s;
            BMU_TEST_ONE_BIT: e.zero = ~s;
            BMU_CARRY_AND_BIT: e.carry = c & s;
            BMU_CARRY_AND_INVERTED_BIT: e.carry = c & ~s;
            BMU_CARRY_OR_BIT: e.carry = c | s;
            BMU_CARRY_OR_INVERTED_BIT: e.carry = c | ~s;
            BMU_CARRY_XOR_BIT: e.carry = c ^ s;
            BMU_CARRY_XOR_INVERTED_BIT: e.carry = c ^ ~s;
            BMU_LOAD_BIT_TO_CARRY: e.carry = s;
            BMU_LOAD_INVERTED_BIT_TO_CARRY: e.carry = ~s;
            BMU_STORE_CARRY_TO_BIT: e.data[b] = c;
            BMU_STORE_INVERTED_CARRY_TO_BIT: e.data[b] = ~c;
            default: e.refused = 1'b1;
        endcase
        e.data_we = !m && (op inside {[BMU_SET_ONE_BIT:BMU_INVERT_ONE_BIT], BMU_STORE_CARRY_TO_BIT,
            BMU_STORE_INVERTED_CARRY_TO_BIT});
        e.carry_we = op inside {[BMU_CARRY_AND_BIT:BMU_LOAD_INVERTED_BIT_TO_CARRY]};
        e.zero_we = (op == BMU_TEST_ONE_BIT);
        return e;
    endfunction
    // one request, then a bounded wait for done; lat_exp of zero skips the latency check
    task automatic run_op(input bmu_req_t r, input int lat_exp);
        int lat;
        @(negedge sys_clk);
        req = r;
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        // only a refused request leaves ready up after the take
        check(ready === (lat_exp == 1), "ready while busy");
        lat = 1;
        while (done !== 1'b1 && lat < 40) begin
            @(negedge sys_clk);
            lat++;
        end
        check(done === 1'b1 && ready === 1'b1, "no done");
        if (done !== 1'b1) begin
            wrap_up();
        end
        if (lat_exp > 0) begin
            check(lat == lat_exp, "latency");
        end
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // every op on a register byte, all four carry and bit pairings
    task automatic t_reg_ops();
        bmu_op_t op;
        logic [7:0] d;
        logic fr;
        for (int j = 0; j < 14; j++) begin
            for (int k = 0; k < 4; k++) begin
                op = bmu_op_t'(j);
                d = k[1] ? 8'hC3 : 8'h3C;
                fr = k[1] && !is_inv(op);
                run_op(mk(op, fr, 3'(j), 1'b0, d, k[0], ~k[0]), 2);
                check(rsp === expect_rsp(op, d, 3'(j), k[0], ~k[0], 1'b0), "reg op rsp");
            end
        end
    endtask
    // inverted ops with a register bit number are refused without touching memory
    task automatic t_refuse();
        bmu_rsp_t e;
        logic [7:0] w0;
        for (int j = 0; j < 14; j++) begin
            if (is_inv(bmu_op_t'(j))) begin
                w0 = wr_count;
                e = '{data: 8'h69, data_we: 1'b0, carry: 1'b1, carry_we: 1'b0, zero: 1'b0, zero_we: 1'b0, refused: 1'b1};
                run_op(mk(bmu_op_t'(j), 1'b1, 3'h2, 1'b1, 8'h69, 1'b1, 1'b0), 1);
                check(rsp === e && wr_count === w0, "refused rsp");
            end
        end
    endtask
    // memory operands, prompt and slow partner, modifying and read-only ops
    task automatic t_mem();
        bmu_op_t ops [4] = '{BMU_SET_ONE_BIT, BMU_STORE_INVERTED_CARRY_TO_BIT, BMU_TEST_ONE_BIT, BMU_CARRY_XOR_BIT};
        // edges to done: prompt or three-wait partner, with or without write-back
        int lat_mem [4] = '{6, 12, 4, 7};
        bmu_rsp_t e;
        logic [7:0] old_byte, w0;
        logic wr;
        for (int j = 0; j < 4; j++) begin
            slow = j[0];
            old_byte = peer.mem[3];
            w0 = wr_count;
            wr = (j < 2);
            e = expect_rsp(ops[j], old_byte, 3'(j + 5), 1'b1, 1'b0, 1'b1);
            run_op(mk(ops[j], j == 0, 3'(j + 5), 1'b1, 8'h00, 1'b1, 1'b0), lat_mem[j]);
            check(rsp === e, "mem rsp");
            check(peer.mem[3] === e.data && wr_count === w0 + 8'(wr), "mem write back");
        end
    endtask

    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        slow = 1'b0;
        repeat (4) @(negedge sys_clk);
        check(ready === 1'b1 && done === 1'b0 && rsp === '0 && mem_rd === 1'b0, "reset values");
        rst_n = 1'b1;
        t_reg_ops();
        t_refuse();
        t_mem();
        check(order_err === 1'b0, "write without read");
        wrap_up();
    end
endmodule
